// ---- design/psr_store.sv ----
// Paged setting register store: six program pages and one common area,
// read and written one item per command, with a retained saved set.
// Assumes commands come from logic on sys_clk; store_clr_n models loss of
// the retained store (first power-up) while rst_n models a restart.
`timescale 1ns/1ps
`default_nettype none
module psr_store
  import psr_pkg::*;
(
  input  wire logic           sys_clk,     // 20 MHz clock
  input  wire logic           rst_n,       // Restart, sync, active low
  input  wire logic           store_clr_n, // Wipe retained store, sync
  input  wire logic           cmd_valid,   // Command offered
  input  wire psr_cmd_type    cmd,         // Command fields
  output logic                cmd_ready,   // Commands taken while high
  output logic                rsp_valid,   // One-cycle answer strobe
  output psr_rsp_type         rsp,         // Ack flag and read data
  output psr_active_type      active       // Settings now in force
);

  // ==========================================================================
  // State
  psr_state_type s_q;
  psr_state_type s_d;
  psr_page_type  pg;
  logic          ok;
  logic [15:0]   rd;

  function automatic psr_active_type view(input psr_set_type st,
                                          input logic [2:0] p);
    psr_active_type a;
    a.page               = p;
    a.flags              = st.page[p].flags;
    a.manual_gain        = st.page[p].manual_gain;
    a.automatic_gain     = st.page[p].automatic_gain;
    a.black_offset       = st.page[p].black_offset;
    // Direct value overrides the table; zero hands back to the switch
    a.exposure           = (st.page[p].direct_exposure != '0) ?
                           st.page[p].direct_exposure :
                           st.page[p].shut_tab[st.vshut_pos[3:0]];
    a.config_flags       = st.config_flags;
    a.substrate_bias     = st.substrate_bias;
    a.ten_bit_monochrome = st.ten_bit_monochrome;
    return a;
  endfunction

  function automatic psr_state_type reset_state(input psr_nv_type nv);
    psr_state_type r;
    r       = '0;
    r.phase = PH_BOOT;
    r.nv    = nv;
    r.cur   = psr_default_set();
    r.act   = view(psr_default_set(), '0);
    return r;
  endfunction

  function automatic logic fits_byte(input logic [15:0] d);
    return d <= BYTE_MAX;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    s_d           = s_q;
    s_d.rsp_valid = 1'b0;
    pg            = s_q.cur.page[s_q.page];
    ok            = 1'b1;
    rd            = '0;
    case (s_q.phase)
      PH_BOOT: begin
        if (s_q.nv.valid && s_q.nv.startup_first) begin
          s_d.cur = s_q.nv.set;
        end else begin
          s_d.cur = psr_default_set();
        end
        s_d.page  = psr_page_index(s_d.cur.vpage_sel);
        s_d.phase = PH_RUN;
        s_d.ready = 1'b1;
      end
      PH_RUN: begin
        if (cmd_valid) begin
          case (cmd.item)
            IT_PAGE_FLAGS: begin
              rd = pg.flags;
              if (cmd.write) pg.flags = cmd.data;
            end
            IT_MANUAL_GAIN: begin
              rd = {8'h00, pg.manual_gain};
              ok = !cmd.write || fits_byte(cmd.data);
              if (cmd.write && ok) pg.manual_gain = cmd.data[7:0];
            end
            IT_AUTOMATIC_GAIN: begin
              rd = {8'h00, pg.automatic_gain};
              ok = !cmd.write || fits_byte(cmd.data);
              if (cmd.write && ok) pg.automatic_gain = cmd.data[7:0];
            end
            IT_BLACK_OFFSET: begin
              rd = {8'h00, pg.black_offset};
              ok = !cmd.write || fits_byte(cmd.data);
              if (cmd.write && ok) pg.black_offset = cmd.data[7:0];
            end
            IT_DIRECT_EXP: begin
              rd = pg.direct_exposure;
              ok = !cmd.write || (cmd.data <= psr_exp_limit(pg.flags));
              if (cmd.write && ok) pg.direct_exposure = cmd.data;
            end
            IT_SHUT_TAB: begin
              ok = {12'h000, cmd.index} <= SHUT_POS_MAX;
              if (ok) rd = pg.shut_tab[cmd.index];
              if (cmd.write && cmd.data > psr_exp_limit(pg.flags)) ok = 1'b0;
              if (cmd.write && ok) pg.shut_tab[cmd.index] = cmd.data;
            end
            IT_CONFIG: begin
              rd = s_q.cur.config_flags;
              if (cmd.write) s_d.cur.config_flags = cmd.data;
            end
            IT_VSHUT_POS: begin
              rd = {8'h00, s_q.cur.vshut_pos};
              ok = !cmd.write || (cmd.data <= SHUT_POS_MAX);
              if (cmd.write && ok) s_d.cur.vshut_pos = cmd.data[7:0];
            end
            IT_VPAGE_SEL: begin
              rd = {8'h00, s_q.cur.vpage_sel};
              ok = !cmd.write || (cmd.data >= {8'h00, PAGE_LETTER_A} &&
                                  cmd.data <= {8'h00, PAGE_LETTER_F});
              if (cmd.write && ok) s_d.cur.vpage_sel = cmd.data[7:0];
            end
            IT_SUBSTRATE_BIAS: begin
              rd = {8'h00, s_q.cur.substrate_bias};
              ok = !cmd.write || fits_byte(cmd.data);
              if (cmd.write && ok) s_d.cur.substrate_bias = cmd.data[7:0];
            end
            IT_SAMPLE_FORMAT: begin
              rd = {15'h0000, s_q.cur.ten_bit_monochrome};
              ok = !cmd.write || (cmd.data <= 16'h0001);
              if (cmd.write && ok) s_d.cur.ten_bit_monochrome = cmd.data[0];
            end
            IT_SAVED_SET_STORE: begin
              rd = {15'h0000, s_q.nv.valid};
              ok = !cmd.write || (cmd.data == SET_FIRST);
              if (cmd.write && ok) begin
                s_d.nv.set   = s_q.cur;
                s_d.nv.valid = 1'b1;
              end
            end
            IT_STARTUP_SET_CHOICE: begin
              rd = {15'h0000, s_q.nv.startup_first};
              ok = !cmd.write || cmd.data == SET_FACTORY || cmd.data == SET_FIRST;
              if (cmd.write && ok) s_d.nv.startup_first = cmd.data[0];
            end
            default: begin
              ok = 1'b0;
            end
          endcase
          // Page write lands on the page active when the command was taken
          s_d.cur.page[s_q.page] = pg;
          if (cmd.item == IT_SAVED_SET_STORE && cmd.write && ok) begin
            s_d.nv.set = s_d.cur;
          end
          s_d.rsp_valid = 1'b1;
          s_d.rsp.ok    = ok;
          s_d.rsp.data  = ok ? rd : '0;
        end
      end
      default: begin
        s_d.phase = PH_BOOT;
      end
    endcase
    s_d.act = view(s_d.cur, s_d.page);
  end

  // ==========================================================================
  // Registers; restart keeps the retained store, unlike a wipe
  always_ff @(posedge sys_clk) begin
    if (!store_clr_n) begin
      s_q <= reset_state('0);
    end else if (!rst_n) begin
      s_q <= reset_state(s_q.nv);
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready = s_q.ready;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp       = s_q.rsp;
  assign active    = s_q.act;

endmodule
`default_nettype wire

// ---- design/psr_pkg.sv ----
// Package for the paged setting register store: item codes, limits,
// field layouts and helper functions shared by the store and its bench.
// Assumes a single 20 MHz clock and a command source on the same clock.
//
// What this block does
// - Settings split into six per-page sets A to F and one common area.
// - Host reads back and modifies every setting register through commands.
// - Each page holds a direct exposure value, checked on write from zero to the mode limit.
// - Each page holds a ten-entry exposure table, positions 0 to 9, limited.
// - Exposure limit is 042A high-speed, 00FF low-speed, 0215 partial scan.
// - Common area holds virtual shutter position, only 0 to 9 accepted.
// - Common area holds virtual page selector, letters A to F only.
// - Common area holds substrate bias as a number 0 to 255.
// - Output samples default to 8-bit mono; host may pick 10-bit mono.
// - Saving to first set and choosing it for start-up restores it later.
// - Factory default start-up choice always boots with default settings.
// - At start-up the page selector letter picks the active page.
package psr_pkg;

  // ==========================================================================
  // Limits and encodings
  localparam int          NUM_PAGES          = 6;
  localparam int          SHUT_TAB_LEN       = 10;
  localparam logic [15:0] EXP_MAX_HIGH       = 16'h042a;
  localparam logic [15:0] EXP_MAX_LOW        = 16'h00ff;
  localparam logic [15:0] EXP_MAX_PARTIAL    = 16'h0215;
  localparam logic [15:0] SHUT_POS_MAX       = 16'h0009;
  localparam logic [7:0]  PAGE_LETTER_A      = 8'h41;
  localparam logic [7:0]  PAGE_LETTER_F      = 8'h46;
  localparam int          FLAG_LOW_SPEED_BIT = 0;
  localparam int          FLAG_PARTIAL_BIT   = 1;
  localparam logic [15:0] SET_FACTORY        = 16'h0000;
  localparam logic [15:0] SET_FIRST          = 16'h0001;
  localparam logic [15:0] BYTE_MAX           = 16'h00ff;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    IT_PAGE_FLAGS, IT_MANUAL_GAIN, IT_AUTOMATIC_GAIN, IT_BLACK_OFFSET,
    IT_DIRECT_EXP, IT_SHUT_TAB, IT_CONFIG, IT_VSHUT_POS, IT_VPAGE_SEL,
    IT_SUBSTRATE_BIAS, IT_SAMPLE_FORMAT, IT_SAVED_SET_STORE,
    IT_STARTUP_SET_CHOICE
  } psr_item_type;

  typedef enum logic {PH_BOOT, PH_RUN} psr_phase_type;

  typedef struct packed {
    logic [15:0]                         flags;
    logic [7:0]                          manual_gain;
    logic [7:0]                          automatic_gain;
    logic [7:0]                          black_offset;
    logic [15:0]                         direct_exposure;
    logic [SHUT_TAB_LEN-1:0][15:0]       shut_tab;
  } psr_page_type;

  typedef struct packed {
    psr_page_type [NUM_PAGES-1:0] page;
    logic [15:0]                  config_flags;
    logic [7:0]                   vshut_pos;
    logic [7:0]                   vpage_sel;
    logic [7:0]                   substrate_bias;
    logic                         ten_bit_monochrome;
  } psr_set_type;

  typedef struct packed {
    logic        valid;
    logic        startup_first;
    psr_set_type set;
  } psr_nv_type;

  typedef struct packed {
    logic [2:0]  page;
    logic [15:0] flags;
    logic [7:0]  manual_gain;
    logic [7:0]  automatic_gain;
    logic [7:0]  black_offset;
    logic [15:0] exposure;
    logic [15:0] config_flags;
    logic [7:0]  substrate_bias;
    logic        ten_bit_monochrome;
  } psr_active_type;

  typedef struct packed {
    logic         write;
    psr_item_type item;
    logic [3:0]   index;
    logic [15:0]  data;
  } psr_cmd_type;

  typedef struct packed {
    logic        ok;
    logic [15:0] data;
  } psr_rsp_type;

  typedef struct packed {
    psr_phase_type  phase;
    psr_nv_type     nv;
    psr_set_type    cur;
    logic [2:0]     page;
    psr_active_type act;
    logic           ready;
    logic           rsp_valid;
    psr_rsp_type    rsp;
  } psr_state_type;

  // ==========================================================================
  // Helpers
  function automatic psr_set_type psr_default_set();
    psr_set_type s;
    s = '0;
    s.vpage_sel = PAGE_LETTER_A;
    return s;
  endfunction

  function automatic logic [15:0] psr_exp_limit(input logic [15:0] flags);
    if (flags[FLAG_PARTIAL_BIT]) return EXP_MAX_PARTIAL;
    else if (flags[FLAG_LOW_SPEED_BIT]) return EXP_MAX_LOW;
    else return EXP_MAX_HIGH;
  endfunction

  function automatic logic [2:0] psr_page_index(input logic [7:0] letter);
    logic [7:0] diff;
    diff = letter - PAGE_LETTER_A;
    return diff[2:0];
  endfunction

endpackage

// ---- sim/psr_store_asserts.sv ----
// Port checker for the paged setting store, bound to every psr_store.
// Assumes one clock; rst_n and store_clr_n both reset the store.
`timescale 1ns/1ps
`default_nettype none
module psr_store_asserts
  import psr_pkg::*;
(
  input wire logic           sys_clk,     // Clock
  input wire logic           rst_n,       // Restart, active low
  input wire logic           store_clr_n, // Store wipe, active low
  input wire logic           cmd_valid,   // Command offered
  input wire psr_cmd_type    cmd,         // Command fields
  input wire logic           cmd_ready,   // Taking commands
  input wire logic           rsp_valid,   // Answer strobe
  input wire psr_rsp_type    rsp,         // Answer
  input wire psr_active_type active       // Settings in force
);
  // ==========================================================================
  // Helpers
  wire logic        tk  = cmd_valid && cmd_ready;
  wire logic        wr  = tk && cmd.write;
  wire logic [7:0]  d8  = cmd.data[7:0];
  // Limit from flags before the write, as the store judges it
  wire logic [15:0] lim = active.flags[FLAG_PARTIAL_BIT] ? EXP_MAX_PARTIAL :
                          active.flags[FLAG_LOW_SPEED_BIT] ? EXP_MAX_LOW : EXP_MAX_HIGH;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !store_clr_n);
  // ==========================================================================
  // Properties
  property p_answer; tk |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer after take");
  property p_quiet; !tk |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without take");
  property p_hold; !rsp_valid && $past(rst_n) && $past(store_clr_n) |-> $stable(rsp); endproperty
  a_hold: assert property (p_hold) else $error("answer changed between strobes");
  property p_nak_zero; rsp_valid && !rsp.ok |-> rsp.data == 16'h0000; endproperty
  a_nak_zero: assert property (p_nak_zero) else $error("refusal carries data");
  property p_exp_lim; wr && cmd.item == IT_DIRECT_EXP && cmd.data > lim |=> !rsp.ok; endproperty
  a_exp_lim: assert property (p_exp_lim) else $error("exposure over limit taken");
  property p_tab_idx; wr && cmd.item == IT_SHUT_TAB && cmd.index > 4'h9 |=> !rsp.ok; endproperty
  a_tab_idx: assert property (p_tab_idx) else $error("table index over 9 taken");
  property p_vshut; wr && cmd.item == IT_VSHUT_POS && cmd.data > SHUT_POS_MAX |=> !rsp.ok;
  endproperty
  a_vshut: assert property (p_vshut) else $error("shutter position over 9 taken");
  property p_vpage; wr && cmd.item == IT_VPAGE_SEL && (cmd.data[15:8] != 8'h00 ||
    d8 < PAGE_LETTER_A || d8 > PAGE_LETTER_F) |=> !rsp.ok; endproperty
  a_vpage: assert property (p_vpage) else $error("page letter out of range taken");
  property p_gain; wr && cmd.item == IT_MANUAL_GAIN && cmd.data <= BYTE_MAX
    |=> active.manual_gain == $past(d8); endproperty
  a_gain: assert property (p_gain) else $error("gain write not in force");
  property p_page_fix; wr && cmd.item == IT_VPAGE_SEL |=> $stable(active.page); endproperty
  a_page_fix: assert property (p_page_fix) else $error("page moved without restart");
  property p_rst; disable iff (1'b0) !rst_n |=> !cmd_ready && !rsp_valid && active.page == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind psr_store psr_store_asserts u_asserts (.sys_clk, .rst_n, .store_clr_n, .cmd_valid, .cmd,
  .cmd_ready, .rsp_valid, .rsp, .active);
`default_nettype wire

// ---- sim/psr_host.sv ----
// Host model: offers one setting command at a time, collects the answer.
// Assumes the store takes a command on a ready edge, answers one cycle on.
`timescale 1ns/1ps
`default_nettype none
module psr_host
  import psr_pkg::*;
(
  input  wire logic        sys_clk,   // Clock
  output logic             cmd_valid, // Command offered
  output psr_cmd_type      cmd,       // Command fields
  input  wire logic        cmd_ready, // Store taking commands
  input  wire logic        rsp_valid, // Answer strobe
  input  wire psr_rsp_type rsp        // Answer
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Fields inverted once taken so stale values never pass for valid ones
  task automatic xfer(input psr_cmd_type c, output psr_rsp_type r, output logic late);
    int n;
    late = 1'b1;
    r = '0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (cmd_ready === 1'b1) break;
    end
    cmd_valid <= 1'b0;
    cmd <= ~c;
    @(posedge sys_clk);
    if (n < 50 && rsp_valid === 1'b1) begin
      late = 1'b0;
      r = rsp;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/psr_store_bench.sv ----
// Bench for psr_store: a command table through the host model, then
// restart, saved-set and wipe cases. The checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module psr_store_bench
  import psr_pkg::*;
;
  localparam logic W = 1'b1, R = 1'b0, Y = 1'b1, N = 1'b0;
  typedef struct packed {psr_cmd_type c; psr_rsp_type r;} psr_row_type;
  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           store_clr_n = 1'b0;
  logic           cmd_valid;
  psr_cmd_type    cmd;
  logic           cmd_ready;
  logic           rsp_valid;
  psr_rsp_type    rsp;
  psr_active_type active;
  int             fail_count = 0;
  int             checks = 0;
  psr_row_type    rows [26];
  always #25 sys_clk = ~sys_clk;
  psr_host u_host (.sys_clk, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp);
  psr_store uut (.sys_clk, .rst_n, .store_clr_n, .cmd_valid, .cmd, .cmd_ready,
    .rsp_valid, .rsp, .active);
  function automatic psr_row_type rw(logic w, psr_item_type it, logic [3:0] ix,
                                     logic [15:0] d, logic ok, logic [15:0] q);
    return '{'{w, it, ix, d}, '{ok, q}};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic run(input psr_row_type w);
    psr_rsp_type r;
    logic        late;
    u_host.xfer(w.c, r, late);
    if (late !== 1'b0) begin
      $display("mismatch at %0t: no answer from store", $time);
      fail_count++;
      tally_and_finish();
    end
    `CHK(r, w.r)
  endtask
  // Held two edges so the store sees a clean level either way
  task automatic restart(input logic wipe);
    rst_n <= 1'b0;
    store_clr_n <= ~wipe;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    store_clr_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  initial begin
    rows = '{
      rw(W, IT_MANUAL_GAIN, 4'h0, 16'h0012, Y, 16'h0000),
      rw(W, IT_MANUAL_GAIN, 4'h0, 16'h0100, N, 16'h0000),
      rw(W, IT_AUTOMATIC_GAIN, 4'h0, 16'h0056, Y, 16'h0000),
      rw(W, IT_AUTOMATIC_GAIN, 4'h0, 16'h0100, N, 16'h0000),
      rw(W, IT_BLACK_OFFSET, 4'h0, 16'h0078, Y, 16'h0000),
      rw(W, IT_BLACK_OFFSET, 4'h0, 16'h01ff, N, 16'h0000),
      rw(W, IT_CONFIG, 4'h0, 16'hbeef, Y, 16'h0000),
      rw(R, IT_CONFIG, 4'h0, 16'h0000, Y, 16'hbeef),
      rw(W, IT_DIRECT_EXP, 4'h0, 16'h042a, Y, 16'h0000),
      rw(W, IT_DIRECT_EXP, 4'h0, 16'h042b, N, 16'h0000),
      rw(W, IT_PAGE_FLAGS, 4'h0, 16'h0002, Y, 16'h0000),
      rw(W, IT_DIRECT_EXP, 4'h0, 16'h0216, N, 16'h0000),
      rw(W, IT_PAGE_FLAGS, 4'h0, 16'h0001, Y, 16'h0002),
      rw(W, IT_DIRECT_EXP, 4'h0, 16'h0100, N, 16'h0000),
      rw(W, IT_DIRECT_EXP, 4'h0, 16'h00ff, Y, 16'h042a),
      rw(R, IT_PAGE_FLAGS, 4'h0, 16'h0000, Y, 16'h0001),
      rw(W, IT_SHUT_TAB, 4'h9, 16'h0005, Y, 16'h0000),
      rw(W, IT_SHUT_TAB, 4'ha, 16'h0005, N, 16'h0000),
      rw(W, IT_VSHUT_POS, 4'h0, 16'h0009, Y, 16'h0000),
      rw(W, IT_VSHUT_POS, 4'h0, 16'h000a, N, 16'h0000),
      rw(W, IT_VPAGE_SEL, 4'h0, 16'h0047, N, 16'h0000),
      rw(W, IT_SUBSTRATE_BIAS, 4'h0, 16'h0100, N, 16'h0000),
      rw(W, IT_SUBSTRATE_BIAS, 4'h0, 16'h00c3, Y, 16'h0000),
      rw(W, IT_SAMPLE_FORMAT, 4'h0, 16'h0001, Y, 16'h0000),
      rw(W, IT_SAMPLE_FORMAT, 4'h0, 16'h0002, N, 16'h0000),
      rw(W, IT_STARTUP_SET_CHOICE, 4'h0, 16'h0002, N, 16'h0000)};
    restart(1'b1);
    for (int i = 0; i < $size(rows); i++) run(rows[i]);
    `CHK(active.exposure, 16'h00ff)
    `CHK(active.ten_bit_monochrome, 1'b1)
    `CHK(active.manual_gain, 8'h12)
    `CHK(active.automatic_gain, 8'h56)
    `CHK(active.black_offset, 8'h78)
    `CHK(active.flags, 16'h0001)
    `CHK(active.config_flags, 16'hbeef)
    `CHK(active.substrate_bias, 8'hc3)
    // Zero direct value hands exposure back to table entry 9
    run(rw(W, IT_DIRECT_EXP, 4'h0, 16'h0000, Y, 16'h00ff));
    `CHK(active.exposure, 16'h0005)
    run(rw(W, IT_VPAGE_SEL, 4'h0, 16'h0043, Y, 16'h0041));
    `CHK(active.page, 3'h0)
    restart(1'b0);
    `CHK(active.page, 3'h0)
    run(rw(R, IT_MANUAL_GAIN, 4'h0, 16'h0000, Y, 16'h0000));
    run(rw(W, IT_MANUAL_GAIN, 4'h0, 16'h0034, Y, 16'h0000));
    run(rw(W, IT_VPAGE_SEL, 4'h0, 16'h0043, Y, 16'h0041));
    run(rw(W, IT_SAVED_SET_STORE, 4'h0, 16'h0001, Y, 16'h0000));
    run(rw(W, IT_STARTUP_SET_CHOICE, 4'h0, 16'h0001, Y, 16'h0000));
    restart(1'b0);
    `CHK(active.page, 3'h2)
    run(rw(R, IT_VPAGE_SEL, 4'h0, 16'h0000, Y, 16'h0043));
    run(rw(R, IT_MANUAL_GAIN, 4'h0, 16'h0000, Y, 16'h0000));
    run(rw(W, IT_SUBSTRATE_BIAS, 4'h0, 16'h00ff, Y, 16'h0000));
    // Factory choice must ignore the saved set that is still held
    run(rw(W, IT_STARTUP_SET_CHOICE, 4'h0, 16'h0000, Y, 16'h0001));
    restart(1'b0);
    `CHK(active.page, 3'h0)
    run(rw(R, IT_SUBSTRATE_BIAS, 4'h0, 16'h0000, Y, 16'h0000));
    run(rw(R, IT_SAVED_SET_STORE, 4'h0, 16'h0000, Y, 16'h0001));
    restart(1'b1);
    run(rw(R, IT_VPAGE_SEL, 4'h0, 16'h0000, Y, 16'h0041));
    tally_and_finish();
  end
endmodule
`default_nettype wire
